// File: verif/serial_ctrl_props.sv
// Port checker for serial_ctrl
// Assumes a bind from the bench top; settings are shadowed from APB writes
`timescale 1ns/1ps
`include "serial_ctrl_regs.svh"

module serial_ctrl_props (
   // Clock, reset and APB
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [19:0]                 paddr,
   input wire logic [31:0]                 pwdata,
   input wire logic [31:0]                 prdata,
   // Pins
   input wire logic                        spi_sck,
   input wire logic                        spi_mosi,
   input wire logic                        scl_i,
   input wire serial_ctrl_pkg::i2c_drive_s i2c_drv
);
   import serial_ctrl_pkg::*;
   logic [1:0]  mode_r;
   logic [5:0]  cfg_r;
   logic [3:0]  lin_r;
   logic [3:0]  shf_r;
   logic [3:0]  quiet_r;
   logic [19:0] gap_r;
   logic [20:0] hn;
   logic        wr_en;
   logic        rd_en;
   logic        set_wr;

   // Decode bus cycles; hn is the half period in reference ticks
   assign wr_en  = psel && penable && pwrite;
   assign rd_en  = psel && penable && !pwrite;
   assign set_wr = wr_en && (paddr inside {`BYTE_ADDR(`IDX_MODE), `BYTE_ADDR(`IDX_SPI_CFG),
                   `BYTE_ADDR(`IDX_RATE_LIN), `BYTE_ADDR(`IDX_RATE_EXP)});
   assign hn     = 21'(lin_r + 5'd1) << shf_r;

   // Shadow settings, count cycles since a setting or sck change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r  <= '0;
         cfg_r   <= '0;
         lin_r   <= '0;
         shf_r   <= '0;
         quiet_r <= '0;
         gap_r   <= '0;
      end else begin
         gap_r   <= $changed(spi_sck) ? '0 : gap_r + 20'(gap_r != '1);
         quiet_r <= set_wr ? '0 : quiet_r + 4'(quiet_r != 4'hf);
         if (wr_en && paddr == `BYTE_ADDR(`IDX_MODE)) mode_r <= pwdata[1:0];
         if (wr_en && paddr == `BYTE_ADDR(`IDX_SPI_CFG)) cfg_r <= pwdata[5:0];
         if (wr_en && paddr == `BYTE_ADDR(`IDX_RATE_LIN)) lin_r <= pwdata[3:0];
         if (wr_en && paddr == `BYTE_ADDR(`IDX_RATE_EXP)) shf_r <= pwdata[3:0];
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_rate_floor: assert property (
      $changed(spi_sck) && mode_r == `MODE_SPI && quiet_r == 4'hf
      |-> 21'(gap_r) + 21'd1 >= (hn << 1)) else $error("sck half period short");
   chk_sck_idle: assert property (
      mode_r == `MODE_OFF && quiet_r == 4'hf |-> spi_sck == cfg_r[0])
      else $error("sck idle level wrong");
   chk_mosi_settled: assert property (
      mode_r == `MODE_SPI && $changed(spi_sck) && ((spi_sck ^ cfg_r[0]) != cfg_r[1])
      |-> $stable(spi_mosi)) else $error("mosi moved on sampling edge");
   chk_stat_upper: assert property (
      rd_en && paddr == `BYTE_ADDR(`IDX_SPI_STAT) |-> prdata[31:4] == '0)
      else $error("status upper bits set");
   chk_cmd_upper: assert property (
      rd_en && paddr == `BYTE_ADDR(`IDX_I2C_CMD) |-> prdata[31:4] == '0)
      else $error("command upper bits set");
   chk_ack_upper: assert property (
      rd_en && paddr == `BYTE_ADDR(`IDX_I2C_ACK) |-> prdata[31:1] == '0)
      else $error("ack register upper bits set");
   chk_i2c_quiet: assert property (
      mode_r != `MODE_I2C && quiet_r == 4'hf |-> !i2c_drv.scl_oe && !i2c_drv.sda_oe)
      else $error("i2c driven outside i2c mode");
   chk_od_low: assert property (
      i2c_drv.scl_o == 1'b0 && i2c_drv.sda_o == 1'b0) else $error("i2c drives high");

   cov_spi_edge: cover property (mode_r == `MODE_SPI && $changed(spi_sck));
   cov_i2c_low: cover property (i2c_drv.sda_oe && scl_i);
   cov_status: cover property (rd_en && paddr == `BYTE_ADDR(`IDX_SPI_STAT));
endmodule

// File: verif/serial_ctrl_spi_i2c_master_tb_top.sv
// Self-checking bench: APB master, peer model, expected-byte queue
// Assumes the checker and peer files compile first
`timescale 1ns/1ps
`include "serial_ctrl_regs.svh"
`define CHK(nm, ex, gt) begin \
   samples_checked++; \
   if ((gt) !== (ex)) begin \
      miscompares++; \
      $display("wrong value %s exp %h got %h", nm, ex, gt); \
   end \
end

module serial_ctrl_spi_i2c_master_tb_top;
   import serial_ctrl_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [19:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdata;
   logic        pready, pslverr, spi_sck, spi_mosi, spi_miso, scl, sda, irq, serr;
   logic        frame_rst = 0, pha_t = 0, ord_t = 0, slv_tx = 0, sda_low, ack_seen;
   logic [7:0]  resp = '0, i2c_resp = '0, got, i2c_got, tx, e8;
   logic [7:0]  exp_q[$];
   logic [19:0] regs[4] = '{`IDX_SPI_CFG, `IDX_RATE_LIN, `IDX_RATE_EXP, `IDX_I2C_ACK};
   logic [31:0] msk[4] = '{32'h3f, 32'hf, 32'hf, 32'h1};
   i2c_drive_s  i2c_drv;
   int          miscompares = 0, samples_checked = 0, cyc = 0;

   // Clock and open-drain wires with pull-ups
   always #10 pclk = ~pclk;
   assign scl = !i2c_drv.scl_oe;
   assign sda = !(i2c_drv.sda_oe || sda_low);

   serial_ctrl u_serial_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .spi_sck(spi_sck),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .scl_i(scl), .sda_i(sda),
      .i2c_drv(i2c_drv), .irq(irq));
   spi_i2c_peer u_spi_i2c_peer (.spi_sck(spi_sck), .spi_mosi(spi_mosi),
      .frame_rst(frame_rst), .pha(pha_t), .ord(ord_t), .resp(resp),
      .spi_miso(spi_miso), .got(got), .scl(scl), .sda(sda), .slv_tx(slv_tx),
      .i2c_resp(i2c_resp), .sda_low(sda_low), .i2c_got(i2c_got), .ack_seen(ack_seen));

   task automatic finish_test();
      if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         finish_test();
      end
   end
   // One APB transfer held until pready is sampled high
   task automatic bus(input logic w, input logic [19:0] i, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= `BYTE_ADDR(i);
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [19:0] i, input logic [31:0] d);
      bus(1'b1, i, d);
   endtask
   task automatic poll(input logic [19:0] i, input logic [31:0] m, input logic [31:0] v);
      int k = 0;
      do begin
         bus(1'b0, i, '0);
         k++;
      end while ((rdata & m) !== v && k < 300);
      `CHK("poll", v, rdata & m)
   endtask
   // Settings only while disabled, master bit always set
   task automatic setup(input logic [31:0] c, input logic [3:0] l, input logic [3:0] s);
      wr(`IDX_MODE, `MODE_OFF);
      wr(`IDX_SPI_CFG, c | 32'h10);
      wr(`IDX_RATE_LIN, l);
      wr(`IDX_RATE_EXP, s);
      {ord_t, pha_t} = c[2:1];
      frame_rst = 1'b1;
      #1 frame_rst = 1'b0;
   endtask
   task automatic spi_xfer(input logic [7:0] t);
      resp = 8'($urandom);
      exp_q.push_back(resp);
      wr(`IDX_DATA, {24'h0, t});
      poll(`IDX_SPI_STAT, 32'h2, 32'h2);
      `CHK("mosi byte", t, got)
      bus(1'b0, `IDX_DATA, '0);
      e8 = exp_q.pop_front();
      `CHK("miso byte", e8, rdata[7:0])
   endtask

   initial begin
      void'($urandom(58));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (regs[j]) begin
         bus(1'b0, regs[j], '0);
         `CHK("reset", 32'h0, rdata)
         wr(regs[j], 32'hffff);
         bus(1'b0, regs[j], '0);
         `CHK("field width", msk[j], rdata)
      end
      bus(1'b1, 20'h044a2, 32'h1);
      `CHK("unmapped", 1'b1, serr)
      wr(`IDX_INT_EN, 32'h7);
      for (int k = 0; k < 8; k++) begin
         setup(k, 4'(k % 3 + 1), 4'(k / 4)); // Half period long enough for miso lag
         wr(`IDX_MODE, `MODE_SPI);
         spi_xfer(8'($urandom));
         `CHK("irq raised", 1'b1, irq)
         bus(1'b0, `IDX_SPI_STAT, '0);
         `CHK("status idle", 32'hc, rdata)
         wr(`IDX_INT_CLR, 32'h7);
         bus(1'b0, `IDX_INT_STAT, '0);
         `CHK("irq cleared", 1'b0, irq)
      end
      // Overrun with the interrupt masked, then unmasked
      wr(`IDX_INT_EN, 32'h0);
      wr(`IDX_DATA, 32'h5a);
      poll(`IDX_SPI_STAT, 32'h2, 32'h2);
      wr(`IDX_DATA, 32'ha5);
      poll(`IDX_SPI_STAT, 32'hf, 32'hf);
      `CHK("irq masked", 1'b0, irq)
      wr(`IDX_INT_EN, 32'h7);
      bus(1'b0, `IDX_INT_STAT, '0);
      `CHK("irq overrun", 1'b1, irq)
      bus(1'b0, `IDX_DATA, '0);
      poll(`IDX_SPI_STAT, 32'hf, 32'hc);
      wr(`IDX_INT_CLR, 32'h7);
      // Receiver-driven underrun: busy byte, then repeat of last byte
      setup(32'h20, 4'h0, 4'h0);
      wr(`IDX_MODE, `MODE_SPI);
      poll(`IDX_SPI_STAT, 32'h2, 32'h2);
      `CHK("busy byte", `BUSY_BYTE, got)
      bus(1'b0, `IDX_DATA, '0);
      poll(`IDX_SPI_STAT, 32'ha, 32'ha);
      setup(32'h28, 4'h0, 4'h0);
      tx = 8'($urandom);
      wr(`IDX_DATA, {24'h0, tx});
      bus(1'b0, `IDX_DATA, '0);
      wr(`IDX_MODE, `MODE_SPI);
      poll(`IDX_SPI_STAT, 32'h2, 32'h2);
      `CHK("first byte", tx, got)
      bus(1'b0, `IDX_DATA, '0);
      poll(`IDX_SPI_STAT, 32'ha, 32'ha);
      `CHK("repeat byte", tx, got)
      // I2C start, send, two receives, stop
      wr(`IDX_MODE, `MODE_OFF);
      wr(`IDX_MODE, `MODE_I2C);
      wr(`IDX_I2C_CMD, 32'h4);
      poll(`IDX_I2C_CMD, 32'hf, 32'h0);
      tx = 8'($urandom);
      wr(`IDX_DATA, {24'h0, tx});
      wr(`IDX_I2C_CMD, 32'h2);
      poll(`IDX_I2C_CMD, 32'hf, 32'h0);
      `CHK("i2c sent", tx, i2c_got)
      for (int a = 1; a >= 0; a--) begin
         i2c_resp = 8'($urandom);
         slv_tx = 1'b1;
         wr(`IDX_I2C_ACK, a);
         wr(`IDX_I2C_CMD, 32'h1);
         poll(`IDX_I2C_CMD, 32'hf, 32'h0);
         slv_tx = 1'b0;
         `CHK("ack driven", a[0], ack_seen)
         bus(1'b0, `IDX_DATA, '0);
         `CHK("i2c got", i2c_resp, rdata[7:0])
      end
      wr(`IDX_INT_CLR, 32'h4);
      wr(`IDX_I2C_CMD, 32'h8);
      poll(`IDX_I2C_CMD, 32'hf, 32'h0);
      poll(`IDX_INT_STAT, 32'h4, 32'h4);
      finish_test();
   end
endmodule

bind serial_ctrl serial_ctrl_props u_serial_ctrl_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .scl_i(scl_i),
   .i2c_drv(i2c_drv));

// File: verif/spi_i2c_peer.sv
// SPI slave and I2C slave on the serial side
// Assumes the bench resolves the I2C wires with pull-ups
`timescale 1ns/1ps

module spi_i2c_peer (
   // SPI side
   input  wire logic       spi_sck,
   input  wire logic       spi_mosi,
   input  wire logic       frame_rst,
   input  wire logic       pha,
   input  wire logic       ord,
   input  wire logic [7:0] resp,
   output logic            spi_miso,
   output logic [7:0]      got,
   // I2C side
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       slv_tx,
   input  wire logic [7:0] i2c_resp,
   output logic            sda_low,
   output logic [7:0]      i2c_got,
   output logic            ack_seen
);
   int e = 0;
   int n = 0;
   int b;
   int idx;

   // Quiet outputs at start
   initial begin
      spi_miso = 1'b0;
      sda_low = 1'b0;
   end
   // Frame boundary restarts edge counting
   always @(posedge frame_rst) e = 0;
   // Capture on sampling edges in the chosen order
   always @(spi_sck) begin
      b = (e % 16) / 2;
      if (e % 2 == pha) got[ord ? b : 7 - b] = spi_mosi;
      e = e + 1;
   end
   // Present next bit; out of frame the line shows the inverse
   always @(e or resp or pha or ord) begin
      idx = (e % 16 + 1) / 2 - pha;
      if (idx >= 0 && idx < 8) spi_miso = resp[ord ? idx : 7 - idx];
      else spi_miso = ~spi_miso;
   end
   // Start condition restarts the bit count
   always @(negedge sda) if (scl) n = 0;
   // Sample on scl rise; the ninth bit is the acknowledge
   always @(posedge scl) begin
      if (n < 8) i2c_got = {i2c_got[6:0], sda};
      if (n == 8) ack_seen = !sda;
      n = n + 1;
   end
   // Drive while scl is low: data when sending, else acknowledge
   always @(negedge scl or slv_tx or i2c_resp) begin
      if (n == 9) n = 0;
      sda_low = slv_tx ? (n < 8 && !i2c_resp[7 - n]) : (n == 8);
   end
endmodule

// File: verilog/rate_gen.sv
// Serial bit-rate generator: one pulse per half SPI or quarter I2C clock period
// Assumes pclk at the system rate; the reference is made by a
// fractional accumulator
`timescale 1ns/1ps
`include "serial_ctrl_regs.svh"

module rate_gen (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Settings
   input  wire logic       run,
   input  wire logic [3:0] lin,
   input  wire logic [3:0] shf,
   // Half-period pulse
   output logic            tick
);
   import serial_ctrl_pkg::*;

   rate_state_s s_r;
   rate_state_s s_nxt;
   logic [6:0]  sum;
   logic [19:0] lim;

   // Reference enable and divisor count
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      sum = {1'b0, s_r.acc} + {1'b0, `REF_MHZ};
      lim = (20'({lin} + 5'd1) << shf) - 20'd1;
      if (!run) begin
         s_nxt.acc = 6'h00;
         s_nxt.cnt = 20'h00000;
      end else if (sum >= {1'b0, `CLK_MHZ}) begin
         s_nxt.acc = 6'(sum - {1'b0, `CLK_MHZ});
         if (s_r.cnt >= lim) begin
            s_nxt.cnt = 20'h00000;
            s_nxt.tick = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 20'd1;
         end
      end else begin
         s_nxt.acc = sum[5:0];
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;

endmodule

// File: verilog/serial_ctrl.sv
// Serial controller: rate, SPI master and I2C master behind APB
// Assumes 50 MHz pclk, external pull-ups on the I2C wires
//
// What this block does
// - SPI rate is 24 MHz over 2*(lin+1)*2^shift, I2C rate over 4*(lin+1)*2^shift, lin four bits
// - Four-bit shift field in its own register scales the divisor
// - Without receiver-driven, a transfer starts when transmit data waits
// - With receiver-driven, a transfer starts when receive space exists
// - Underrun sends 0xff, or repeats last byte when repeat is set
// - Repeat change applies only with transmit empty and shifter idle
// - Bit order clear shifts MSB first, set shifts LSB first
// - Phase clear samples on leading edge, set on second edge
// - Polarity clear gives rising leading edge, set falling
// - Receive overrun flag sets on overflow, clears on data read
// - After each received I2C byte drive ACK if set, else NACK
`timescale 1ns/1ps
`include "serial_ctrl_regs.svh"

module serial_ctrl (
   // Clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // APB slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [19:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic                           pready,
   output logic [31:0]                    prdata,
   output logic                           pslverr,
   // SPI pins
   output logic                           spi_sck,
   output logic                           spi_mosi,
   input  wire logic                      spi_miso,
   // I2C pins
   input  wire logic                      scl_i,
   input  wire logic                      sda_i,
   output serial_ctrl_pkg::i2c_drive_s    i2c_drv,
   // Interrupt
   output logic                           irq
);
   import serial_ctrl_pkg::*;

   ctrl_state_s s_r;
   ctrl_state_s n;
   logic        tk;
   logic        wr;
   logic        rd;
   logic        setup;
   logic        hit;
   logic [31:0] rmux;
   logic [2:0]  ev;
   logic        miso_s;
   logic        scl_s;
   logic        sda_s;
   logic        lead;
   logic        samp;
   logic [7:0]  rnew;
   logic [7:0]  ld;
   logic        lsb;

   // Rate generator runs whenever the controller is enabled
   rate_gen u_rate (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (s_r.mode != `MODE_OFF),
      .lin     (s_r.lin),
      .shf     (s_r.shf),
      .tick    (tk)
   );

   // APB phase decode
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign prdata = s_r.prdata;
   assign pslverr = psel & penable & ~hit;

   // Second synchroniser stage feeds the logic; miso needs two pclk to arrive
   assign miso_s = s_r.sy2[0];
   assign scl_s = s_r.sy2[1];
   assign sda_s = s_r.sy2[2];
   assign lsb = s_r.cfg[`CFG_ORD];

   // Address decode and read mux
   always_comb begin
      hit = 1'b1;
      rmux = 32'h00000000;
      case (paddr)
         `BYTE_ADDR(`IDX_SPI_STAT): begin
            rmux[3] = ~s_r.txv & (s_r.st == SPI_IDLE);
            rmux[2] = ~s_r.txv;
            rmux[1] = s_r.rxv;
            rmux[0] = s_r.ovf;
         end
         `BYTE_ADDR(`IDX_I2C_CMD): begin
            rmux[3:0] = s_r.cmd;
         end
         `BYTE_ADDR(`IDX_I2C_ACK): begin
            rmux[0] = s_r.ack;
         end
         `BYTE_ADDR(`IDX_SPI_CFG): begin
            rmux[5:0] = s_r.cfg;
         end
         `BYTE_ADDR(`IDX_RATE_LIN): begin
            rmux[3:0] = s_r.lin;
         end
         `BYTE_ADDR(`IDX_RATE_EXP): begin
            rmux[3:0] = s_r.shf;
         end
         `BYTE_ADDR(`IDX_MODE): begin
            rmux[1:0] = s_r.mode;
         end
         `BYTE_ADDR(`IDX_DATA): begin
            rmux[7:0] = s_r.rxd;
         end
         `BYTE_ADDR(`IDX_INT_STAT): begin
            rmux[2:0] = s_r.ist_r;
         end
         `BYTE_ADDR(`IDX_INT_EN): begin
            rmux[2:0] = s_r.ien;
         end
         `BYTE_ADDR(`IDX_INT_CLR): begin
            rmux = 32'h00000000;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Next-state logic for bus, SPI engine, I2C engine and interrupts
   always_comb begin
      n = s_r;
      ev = 3'b000;
      lead = ~s_r.ecnt[0];
      samp = lead ^ s_r.cfg[`CFG_PHA];
      rnew = lsb ? {miso_s, s_r.rsh[7:1]} : {s_r.rsh[6:0], miso_s};
      ld = s_r.txv ? s_r.txd : (s_r.rpt ? s_r.last : `BUSY_BYTE);
      n.sy1 = {sda_i, scl_i, spi_miso};
      n.sy2 = s_r.sy1;

      // Read data is captured in the setup phase
      if (setup) begin
         n.prdata = rmux;
      end

      // Register writes; rate and config are taken as written
      if (wr && hit) begin
         case (paddr)
            `BYTE_ADDR(`IDX_I2C_CMD):  n.cmd = pwdata[3:0];
            `BYTE_ADDR(`IDX_I2C_ACK):  n.ack = pwdata[0];
            `BYTE_ADDR(`IDX_SPI_CFG):  n.cfg = pwdata[5:0];
            `BYTE_ADDR(`IDX_RATE_LIN): n.lin = pwdata[3:0];
            `BYTE_ADDR(`IDX_RATE_EXP): n.shf = pwdata[3:0];
            `BYTE_ADDR(`IDX_MODE):     n.mode = pwdata[1:0];
            `BYTE_ADDR(`IDX_INT_EN):   n.ien = pwdata[2:0];
            `BYTE_ADDR(`IDX_INT_CLR):  n.ist_r = s_r.ist_r & ~pwdata[2:0];
            `BYTE_ADDR(`IDX_DATA): begin
               n.txd = pwdata[7:0];
               n.txv = 1'b1;
            end
            default: begin
               n.txv = n.txv;
            end
         endcase
      end

      // Reading the data port pops the byte and clears overrun
      if (rd && paddr == `BYTE_ADDR(`IDX_DATA)) begin
         n.rxv = 1'b0;
         n.ovf = 1'b0;
      end

      // SPI engine
      case (s_r.st)
         SPI_IDLE: begin
            n.sck = 1'b0;
            n.ecnt = 4'h0;
            if (!s_r.txv) begin
               n.rpt = s_r.cfg[`CFG_RPT];
            end
            if (s_r.mode == `MODE_SPI &&
                (s_r.cfg[`CFG_RXDRV] ? !s_r.rxv
                                     : s_r.txv)) begin
               n.st = SPI_XFER;
               n.tsh = ld;
               if (s_r.txv) begin
                  n.last = s_r.txd;
                  n.txv = 1'b0;
               end
            end
         end
         SPI_XFER: begin
            if (tk) begin
               n.sck = ~s_r.sck;
               n.ecnt = s_r.ecnt + 4'h1;
               if (samp) begin
                  n.rsh = rnew;
               end else if (!(s_r.cfg[`CFG_PHA] && s_r.ecnt == 4'h0)) begin
                  n.tsh = lsb ? {1'b0, s_r.tsh[7:1]}
                              : {s_r.tsh[6:0], 1'b0};
               end
               if (s_r.ecnt == 4'hf) begin
                  n.st = SPI_IDLE;
                  n.rxd = samp ? rnew : s_r.rsh;
                  n.rxv = 1'b1;
                  ev[0] = 1'b1;
                  if (s_r.rxv && !(rd && paddr == `BYTE_ADDR(`IDX_DATA))) begin
                     n.ovf = 1'b1;
                     ev[1] = 1'b1;
                  end
               end
            end
         end
         default: begin
            n.st = SPI_IDLE;
         end
      endcase

      // I2C engine: four quarter steps per bit or condition
      case (s_r.ist)
         I2C_IDLE: begin
            n.step = 2'h0;
            n.bitn = 4'h0;
            if (s_r.mode == `MODE_I2C && s_r.cmd != 4'h0) begin
               n.ist = I2C_RUN;
               if (s_r.cmd[`CMD_STOP]) begin
                  n.iop = 4'b1000;
               end else if (s_r.cmd[`CMD_START]) begin
                  n.iop = 4'b0100;
               end else if (s_r.cmd[`CMD_SEND]) begin
                  n.iop = 4'b0010;
                  n.ish = s_r.txd;
                  n.txv = 1'b0;
               end else begin
                  n.iop = 4'b0001;
               end
            end
         end
         I2C_RUN: begin
            if (tk) begin
               case (s_r.step)
                  2'h0: begin
                     n.step = 2'h1;
                     if (s_r.iop[`CMD_STOP]) begin
                        n.sda_lo = 1'b1;
                     end else if (s_r.iop[`CMD_START]) begin
                        n.sda_lo = 1'b0;
                     end else if (s_r.bitn == 4'h8) begin
                        n.sda_lo = s_r.iop[`CMD_RECV] & s_r.ack;
                     end else begin
                        n.sda_lo = s_r.iop[`CMD_SEND] & ~s_r.ish[7];
                     end
                  end
                  2'h1: begin
                     n.step = 2'h2;
                     n.scl_lo = 1'b0;
                  end
                  2'h2: begin
                     // Waits while a slave stretches the clock
                     if (scl_s) begin
                        n.step = 2'h3;
                        if (s_r.iop[`CMD_STOP]) begin
                           n.sda_lo = 1'b0;
                        end else if (s_r.iop[`CMD_START]) begin
                           n.sda_lo = 1'b1;
                        end else if (s_r.bitn != 4'h8) begin
                           n.ish = {s_r.ish[6:0], sda_s};
                        end
                     end
                  end
                  default: begin
                     n.step = 2'h0;
                     n.scl_lo = ~s_r.iop[`CMD_STOP];
                     n.bitn = s_r.bitn + 4'h1;
                     if (s_r.iop[`CMD_STOP] || s_r.iop[`CMD_START] ||
                         s_r.bitn == 4'h8) begin
                        n.ist = I2C_IDLE;
                        n.cmd = n.cmd & ~s_r.iop;
                        ev[2] = 1'b1;
                        if (s_r.iop[`CMD_RECV]) begin
                           n.rxd = s_r.ish;
                           n.rxv = 1'b1;
                           if (s_r.rxv) begin
                              n.ovf = 1'b1;
                              ev[1] = 1'b1;
                           end
                        end
                     end
                  end
               endcase
            end
         end
         default: begin
            n.ist = I2C_IDLE;
         end
      endcase

      // Sticky interrupt status; a new event beats a clear
      n.ist_r = n.ist_r | ev;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.st <= SPI_IDLE;
         s_r.ist <= I2C_IDLE;
      end else begin
         s_r <= n;
      end
   end

   // Pin drive
   assign spi_sck = s_r.sck ^ s_r.cfg[`CFG_POL];
   assign spi_mosi = lsb ? s_r.tsh[0] : s_r.tsh[7];
   assign i2c_drv.scl_o = 1'b0;
   assign i2c_drv.scl_oe = s_r.scl_lo;
   assign i2c_drv.sda_o = 1'b0;
   assign i2c_drv.sda_oe = s_r.sda_lo;

   // Level interrupt from enabled status bits
   assign irq = |(s_r.ist_r & s_r.ien);

endmodule

// File: verilog/serial_ctrl_pkg.sv
// Types shared by the serial controller files
// Assumes the register header is on the include path
package serial_ctrl_pkg;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b01,
      SPI_XFER = 2'b10
   } spi_state_e;

   typedef enum logic [1:0] {
      I2C_IDLE = 2'b01,
      I2C_RUN  = 2'b10
   } i2c_state_e;

   // Open-drain pin drive towards the bus
   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } i2c_drive_s;

   typedef struct packed {
      logic [5:0]  acc;
      logic [19:0] cnt;
      logic        tick;
   } rate_state_s;

   typedef struct packed {
      spi_state_e  st;
      i2c_state_e  ist;
      logic [1:0]  mode;
      logic [3:0]  lin;
      logic [3:0]  shf;
      logic [5:0]  cfg;
      logic        rpt;
      logic [3:0]  cmd;
      logic [3:0]  iop;
      logic        ack;
      logic [7:0]  txd;
      logic        txv;
      logic [7:0]  rxd;
      logic        rxv;
      logic        ovf;
      logic [7:0]  last;
      logic [7:0]  tsh;
      logic [7:0]  rsh;
      logic [3:0]  ecnt;
      logic        sck;
      logic [3:0]  bitn;
      logic [1:0]  step;
      logic        scl_lo;
      logic        sda_lo;
      logic [7:0]  ish;
      logic [2:0]  sy1;
      logic [2:0]  sy2;
      logic [2:0]  ist_r;
      logic [2:0]  ien;
      logic [31:0] prdata;
   } ctrl_state_s;

endpackage

// File: verilog/serial_ctrl_regs.svh
// Register map, field positions, reset values and rate constants
// Assumes byte addresses on APB are four times the register index
`ifndef SERIAL_CTRL_REGS_SVH
`define SERIAL_CTRL_REGS_SVH

// Register indices
`define IDX_SPI_STAT  20'h044a0
`define IDX_I2C_CMD   20'h044a6
`define IDX_I2C_ACK   20'h044a8
`define IDX_SPI_CFG   20'h044ac
`define IDX_RATE_LIN  20'h044b0
`define IDX_RATE_EXP  20'h044b2
`define IDX_MODE      20'h044c0
`define IDX_DATA      20'h044c2
`define IDX_INT_STAT  20'h044c4
`define IDX_INT_EN    20'h044c6
`define IDX_INT_CLR   20'h044c8
`define BYTE_ADDR(i)  ((i) << 2)

// Field positions
`define CFG_POL   0
`define CFG_PHA   1
`define CFG_ORD   2
`define CFG_RPT   3
`define CFG_MST   4
`define CFG_RXDRV 5
`define CMD_RECV  0
`define CMD_SEND  1
`define CMD_START 2
`define CMD_STOP  3

// Modes and values
`define MODE_OFF  2'h0
`define MODE_SPI  2'h2
`define MODE_I2C  2'h3
`define BUSY_BYTE 8'hff
`define RST_ZERO  8'h00

// Rate: reference and system clock in MHz
`define REF_MHZ   6'd24
`define CLK_MHZ   6'd50

`endif
